// ===== rtl/ddt_defs.svh
// Constants of the dual down-timer block: register offsets, field
// positions, reset values and prescaler masks.
// Assumes inclusion by bare name from the design file and the testbench.
`ifndef DDT_DEFS_SVH
`define DDT_DEFS_SVH

// ****************************************
// Register offsets
// ****************************************
`define DDT_ADDR_W 3
`define DDT_DATA_W 8
`define DDT_OFS_CTRL 3'h0
`define DDT_OFS_MODE 3'h1
`define DDT_OFS_CL0 3'h2
`define DDT_OFS_CH0 3'h3
`define DDT_OFS_CL1 3'h4
`define DDT_OFS_CH1 3'h5
`define DDT_OFS_CFG 3'h6
`define DDT_OFS_CSEL 3'h7

// ****************************************
// Field positions
// ****************************************
`define DDT_CTRL_T0_RUN 0
`define DDT_CTRL_T0_FULL 1
`define DDT_CTRL_T1_RUN 2
`define DDT_CTRL_T1_FULL 3
`define DDT_MODE_XTAL_EN 3
`define DDT_CFG_ENABLE 0
`define DDT_CSEL_T1_LSB 4

// ****************************************
// Reset values
// ****************************************
`define DDT_RST_BYTE 8'h00
`define DDT_RST_CSEL 7'h00

// ****************************************
// Prescaler masks
// ****************************************
`define DDT_DIV8_MASK 9'h007
`define DDT_DIV32_MASK 9'h01f
`define DDT_DIV128_MASK 9'h07f
`define DDT_DIV512_MASK 9'h1ff
`define DDT_DIV6_LAST 3'h5

`endif

// ===== rtl/ddt_pkg.sv
// Types of the dual down-timer block.
// Assumes ddt_defs.svh is on the include path.
package ddt_pkg;

    // ****************************************
    // Operating modes
    // ****************************************
    typedef enum logic [2:0] {
        DDT_MODE0 = 3'h0,
        DDT_MODE1 = 3'h1,
        DDT_MODE2 = 3'h2,
        DDT_MODE3 = 3'h3,
        DDT_MODE4 = 3'h4,
        DDT_MODE5 = 3'h5,
        DDT_MODE6 = 3'h6,
        DDT_MODE7 = 3'h7
    } ddt_mode_t;

    // ****************************************
    // Run and full bits, low nibble of control
    // ****************************************
    typedef struct packed {
        logic t1_underflow_flag;
        logic t1_run_a;
        logic t0_underflow_flag;
        logic t0_run;
    } ddt_ctrl_t;

endpackage

// ===== rtl/ddt_timer.sv
// Dual down-timer module: seven counting modes on eight mode codes (seven acts as six) over four byte registers,
// a register port with one-cycle read latency, selectable count clocks.
// Assumes oscillator and pin inputs are asynchronous levels and that
// clk_i is the register-loading system clock.
`timescale 1ns/1ps
`include "ddt_defs.svh"

module ddt_timer
    import ddt_pkg::*;
#(
    parameter int NSRC = 5
) (
    // Clock and reset
    input wire logic clk_i,
    input wire logic reset_i,
    // Register port
    input wire logic [`DDT_ADDR_W-1:0] addr_i,
    input wire logic [`DDT_DATA_W-1:0] wdata_i,
    input wire logic we_i,
    input wire logic re_i,
    output logic [`DDT_DATA_W-1:0] rdata_o,
    // Oscillators and pin
    input wire logic rc12_osc_i,
    input wire logic lp_osc_i,
    input wire logic rc90_osc_i,
    input wire logic xtal_osc_i,
    input wire logic wake_io_pin_i,
    // Baud tick to the transmitter
    output logic baud_tick_o
);

    // ****************************************
    // Helpers
    // ****************************************
    function automatic logic [16:0] step16(input logic [15:0] cnt, input logic [15:0] rld,
                                           input logic reload);
        logic [16:0] res;
        res = {1'b0, cnt - 16'h0001};
        if (cnt == 16'h0000) begin
            res = {1'b1, reload ? rld : cnt};
        end
        return res;
    endfunction

    function automatic logic [8:0] step8(input logic [7:0] cnt, input logic [7:0] rld,
                                         input logic reload);
        logic [8:0] res;
        res = {1'b0, cnt - 8'h01};
        if (cnt == 8'h00) begin
            res = {1'b1, reload ? rld : cnt};
        end
        return res;
    endfunction

    function automatic logic pick(input logic [3:0] sel, input logic [9:0] ticks);
        logic hit;
        hit = 1'b0;
        if (sel < 4'ha) begin
            hit = ticks[sel];
        end
        return hit;
    endfunction

    // ****************************************
    // State
    // ****************************************
    ddt_ctrl_t ctrl_r, ctrl_nxt;
    ddt_mode_t mode_r, mode_nxt;
    logic xtal_en_r, xtal_en_nxt;
    logic enable_r, enable_nxt;
    logic [6:0] csel_r, csel_nxt;
    logic [7:0] tl0_r, tl0_nxt, th0_r, th0_nxt, tl1_r, tl1_nxt, th1_r, th1_nxt;
    logic [7:0] rdata_r, rdata_nxt, rd_val;
    logic baud_r, baud_nxt, t1_evt_r, t1_evt_nxt;
    logic [8:0] rc_div_r, rc_div_nxt, xd512_r, xd512_nxt;
    logic [2:0] xd6_r, xd6_nxt, r90_r, r90_nxt;
    logic [NSRC-1:0] src, rise, chg;
    logic [9:0] tk0_vec, tk1_vec;
    logic tk0, tk1, uf0, uf1, uf2, rl0, rl1, xrise;

    assign src = {wake_io_pin_i, xtal_osc_i, rc90_osc_i, lp_osc_i, rc12_osc_i};

    // ****************************************
    // Input synchronisers
    // ****************************************
    // Three stages; a level counts once stages two and three agree
    genvar g;
    generate
        for (g = 0; g < NSRC; g++) begin : g_sync
            logic [2:0] sh_r, sh_nxt;
            logic stb_r, stb_nxt;
            always_comb begin
                sh_nxt = {sh_r[1:0], src[g]};
                stb_nxt = (sh_r[1] == sh_r[2]) ? sh_r[2] : stb_r;
            end
            always_ff @(posedge clk_i or posedge reset_i) begin
                if (reset_i) begin
                    sh_r <= 3'h0;
                    stb_r <= 1'b0;
                end else begin
                    sh_r <= sh_nxt;
                    stb_r <= stb_nxt;
                end
            end
            assign rise[g] = stb_nxt & ~stb_r;
            assign chg[g] = stb_nxt ^ stb_r;
        end
    endgenerate

    // ****************************************
    // Prescalers and clock selection
    // ****************************************
    // Dividers are held cleared while disabled to save power
    always_comb begin
        xrise = rise[3] & xtal_en_r;
        rc_div_nxt = rc_div_r;
        xd512_nxt = xd512_r;
        xd6_nxt = xd6_r;
        r90_nxt = r90_r;
        if (rise[0]) begin
            rc_div_nxt = rc_div_r + 9'h001;
        end
        if (xrise) begin
            xd512_nxt = xd512_r + 9'h001;
            xd6_nxt = (xd6_r == `DDT_DIV6_LAST) ? 3'h0 : xd6_r + 3'h1;
        end
        if (rise[2]) begin
            r90_nxt = r90_r + 3'h1;
        end
        if (!enable_r) begin
            rc_div_nxt = 9'h000;
            xd512_nxt = 9'h000;
            xd6_nxt = 3'h0;
            r90_nxt = 3'h0;
        end
        // Prescaling runs on the raw RC edges, not on the system divider
        tk0_vec[0] = rise[0];
        tk0_vec[1] = rise[0] && ((rc_div_r & `DDT_DIV8_MASK) == `DDT_DIV8_MASK);
        tk0_vec[2] = rise[0] && ((rc_div_r & `DDT_DIV32_MASK) == `DDT_DIV32_MASK);
        tk0_vec[3] = rise[0] && ((rc_div_r & `DDT_DIV128_MASK) == `DDT_DIV128_MASK);
        tk0_vec[4] = rise[0] && ((rc_div_r & `DDT_DIV512_MASK) == `DDT_DIV512_MASK);
        tk0_vec[5] = chg[1];
        tk0_vec[6] = xrise && (xd6_r == `DDT_DIV6_LAST);
        tk0_vec[7] = t1_evt_r;
        tk0_vec[8] = xrise && (xd512_r == `DDT_DIV512_MASK);
        tk0_vec[9] = rise[2] && (r90_r == 3'h7);
        tk1_vec = {2'b00, rise[4], tk0_vec[6:0]};
        tk0 = pick(csel_r[3:0], tk0_vec) & enable_r;
        tk1 = pick({1'b0, csel_r[6:4]}, tk1_vec) & enable_r;
    end

    // ****************************************
    // Counters and register writes
    // ****************************************
    always_comb begin
        ctrl_nxt = ctrl_r;
        mode_nxt = mode_r;
        xtal_en_nxt = xtal_en_r;
        enable_nxt = enable_r;
        csel_nxt = csel_r;
        tl0_nxt = tl0_r;
        th0_nxt = th0_r;
        tl1_nxt = tl1_r;
        th1_nxt = th1_r;
        uf0 = 1'b0;
        uf1 = 1'b0;
        uf2 = 1'b0;
        rl0 = 1'b0;
        rl1 = 1'b0;
        unique case (mode_r)
            DDT_MODE0: begin
                rl0 = 1'b1;
                if (ctrl_r.t0_run && tk0) begin
                    {uf0, th0_nxt, tl0_nxt} = step16({th0_r, tl0_r}, {8'h00, tl1_r}, 1'b1);
                end
            end
            DDT_MODE1: begin
                rl1 = 1'b1;
                if (ctrl_r.t0_run && tk0) begin
                    {uf0, th0_nxt, tl0_nxt} = step16({th0_r, tl0_r}, 16'h0000, 1'b0);
                end
                if (ctrl_r.t1_run_a && tk1) begin
                    {uf1, tl1_nxt} = step8(tl1_r, th1_r, 1'b1);
                end
            end
            DDT_MODE2: begin
                rl0 = 1'b1;
                rl1 = 1'b1;
                if (ctrl_r.t0_run && tk0) begin
                    {uf0, tl0_nxt} = step8(tl0_r, th0_r, 1'b1);
                end
                if (ctrl_r.t1_run_a && tk1) begin
                    {uf1, tl1_nxt} = step8(tl1_r, th1_r, 1'b1);
                end
            end
            DDT_MODE3: begin
                if (ctrl_r.t0_run && tk0) begin
                    {uf0, tl0_nxt} = step8(tl0_r, 8'h00, 1'b0);
                end
                if (ctrl_r.t1_run_a && tk0) begin
                    {uf1, th0_nxt} = step8(th0_r, 8'h00, 1'b0);
                end
                // Third timer has no run bit; it runs whenever enabled
                if (tk1) begin
                    {uf2, tl1_nxt} = step8(tl1_r, th1_r, 1'b1);
                end
            end
            DDT_MODE4: begin
                rl1 = 1'b1;
                if (ctrl_r.t1_run_a && tk1) begin
                    {uf1, th1_nxt, tl1_nxt} = step16({th1_r, tl1_r}, {th0_r, tl0_r}, 1'b1);
                end
            end
            DDT_MODE5: begin
                rl0 = 1'b1;
                if (ctrl_r.t0_run && tk0) begin
                    {uf0, tl0_nxt} = step8(tl0_r, th0_r, 1'b1);
                end
                if (ctrl_r.t1_run_a && tk1) begin
                    {uf1, th1_nxt, tl1_nxt} = step16({th1_r, tl1_r}, 16'h0000, 1'b0);
                end
            end
            // Mode seven is left to calibration firmware; it acts as mode six
            DDT_MODE6, DDT_MODE7: begin
                if (ctrl_r.t0_run && tk0) begin
                    {uf0, th0_nxt, tl0_nxt} = step16({th0_r, tl0_r}, 16'h0000, 1'b0);
                end
                if (ctrl_r.t1_run_a && tk1) begin
                    {uf1, th1_nxt, tl1_nxt} = step16({th1_r, tl1_r}, 16'h0000, 1'b0);
                end
            end
        endcase
        // Flags are only polled; there is no interrupt line
        if (uf0) begin
            ctrl_nxt.t0_underflow_flag = 1'b1;
            ctrl_nxt.t0_run = ctrl_r.t0_run & rl0;
        end
        if (uf1) begin
            ctrl_nxt.t1_underflow_flag = 1'b1;
            ctrl_nxt.t1_run_a = ctrl_r.t1_run_a & rl1;
        end
        if (we_i) begin
            case (addr_i)
                `DDT_OFS_CTRL: begin
                    ctrl_nxt.t0_run = wdata_i[`DDT_CTRL_T0_RUN];
                    ctrl_nxt.t1_run_a = wdata_i[`DDT_CTRL_T1_RUN];
                    // A same-cycle underflow beats the software clear
                    ctrl_nxt.t0_underflow_flag = wdata_i[`DDT_CTRL_T0_FULL] | uf0;
                    ctrl_nxt.t1_underflow_flag = wdata_i[`DDT_CTRL_T1_FULL] | uf1;
                end
                `DDT_OFS_MODE: begin
                    mode_nxt = ddt_mode_t'(wdata_i[2:0]);
                    xtal_en_nxt = wdata_i[`DDT_MODE_XTAL_EN];
                end
                `DDT_OFS_CL0: tl0_nxt = wdata_i;
                `DDT_OFS_CH0: th0_nxt = wdata_i;
                `DDT_OFS_CL1: tl1_nxt = wdata_i;
                `DDT_OFS_CH1: th1_nxt = wdata_i;
                `DDT_OFS_CFG: enable_nxt = wdata_i[`DDT_CFG_ENABLE];
                `DDT_OFS_CSEL: csel_nxt = wdata_i[6:0];
                default: begin
                end
            endcase
        end
        baud_nxt = (((mode_r == DDT_MODE1) || (mode_r == DDT_MODE2)) && uf1)
                   || ((mode_r == DDT_MODE3) && uf2);
        t1_evt_nxt = uf1 | uf2;
    end

    // ****************************************
    // Read path
    // ****************************************
    always_comb begin
        case (addr_i)
            `DDT_OFS_CTRL: rd_val = {4'h0, ctrl_r};
            `DDT_OFS_MODE: rd_val = {4'h0, xtal_en_r, mode_r};
            `DDT_OFS_CL0: rd_val = tl0_r;
            `DDT_OFS_CH0: rd_val = th0_r;
            `DDT_OFS_CL1: rd_val = tl1_r;
            `DDT_OFS_CH1: rd_val = th1_r;
            `DDT_OFS_CFG: rd_val = {7'h00, enable_r};
            default: rd_val = {1'b0, csel_r};
        endcase
        rdata_nxt = re_i ? rd_val : 8'h00;
    end

    always_ff @(posedge clk_i or posedge reset_i) begin
        if (reset_i) begin
            ctrl_r <= '0;
            mode_r <= DDT_MODE0;
            xtal_en_r <= 1'b0;
            enable_r <= 1'b0;
            csel_r <= `DDT_RST_CSEL;
            tl0_r <= `DDT_RST_BYTE;
            th0_r <= `DDT_RST_BYTE;
            tl1_r <= `DDT_RST_BYTE;
            th1_r <= `DDT_RST_BYTE;
            rdata_r <= `DDT_RST_BYTE;
            baud_r <= 1'b0;
            t1_evt_r <= 1'b0;
            rc_div_r <= 9'h000;
            xd512_r <= 9'h000;
            xd6_r <= 3'h0;
            r90_r <= 3'h0;
        end else begin
            ctrl_r <= ctrl_nxt;
            mode_r <= mode_nxt;
            xtal_en_r <= xtal_en_nxt;
            enable_r <= enable_nxt;
            csel_r <= csel_nxt;
            tl0_r <= tl0_nxt;
            th0_r <= th0_nxt;
            tl1_r <= tl1_nxt;
            th1_r <= th1_nxt;
            rdata_r <= rdata_nxt;
            baud_r <= baud_nxt;
            t1_evt_r <= t1_evt_nxt;
            rc_div_r <= rc_div_nxt;
            xd512_r <= xd512_nxt;
            xd6_r <= xd6_nxt;
            r90_r <= r90_nxt;
        end
    end

    assign rdata_o = rdata_r;
    assign baud_tick_o = baud_r;

    // ****************************************
    // Assertions
    // ****************************************
    default clocking cb @(posedge clk_i);
    endclocking
    default disable iff (reset_i);

    sequence s_m6_t0_zero;
        mode_r == DDT_MODE6 && ctrl_r.t0_run && tk0 && {th0_r, tl0_r} == 16'h0000 && !we_i;
    endsequence

    property p_disabled_hold;
        !enable_r && !we_i |=> $stable(tl0_r) && $stable(th0_r) && $stable(tl1_r)
            && $stable(th1_r);
    endproperty
    a_disabled_hold: assert property (p_disabled_hold) else $error("count while disabled");

    property p_nonreload_stop;
        s_m6_t0_zero |=> !ctrl_r.t0_run && ctrl_r.t0_underflow_flag;
    endproperty
    a_nonreload_stop: assert property (p_nonreload_stop) else $error("no stop on underflow");

    property p_stays_stopped;
        s_m6_t0_zero ##1 (!we_i) [*2] |-> !ctrl_r.t0_run && {th0_r, tl0_r} == 16'h0000;
    endproperty
    a_stays_stopped: assert property (p_stays_stopped) else $error("restarted by itself");

    property p_reload8;
        mode_r == DDT_MODE2 && ctrl_r.t0_run && tk0 && tl0_r == 8'h00 && !we_i
            |=> tl0_r == $past(th0_r) && ctrl_r.t0_underflow_flag && ctrl_r.t0_run;
    endproperty
    a_reload8: assert property (p_reload8) else $error("8-bit reload wrong");

    property p_dec;
        mode_r == DDT_MODE2 && ctrl_r.t1_run_a && tk1 && tl1_r != 8'h00 && !we_i
            |=> tl1_r == $past(tl1_r) - 8'h01;
    endproperty
    a_dec: assert property (p_dec) else $error("no decrement on tick");

    property p_wr_override;
        we_i && addr_i == `DDT_OFS_CL1 |=> tl1_r == $past(wdata_i);
    endproperty
    a_wr_override: assert property (p_wr_override) else $error("write lost");

    property p_full_set_wins;
        uf0 && we_i && addr_i == `DDT_OFS_CTRL && !wdata_i[`DDT_CTRL_T0_FULL]
            |=> ctrl_r.t0_underflow_flag;
    endproperty
    a_full_set_wins: assert property (p_full_set_wins) else $error("underflow lost");

    property p_mode0_reload;
        mode_r == DDT_MODE0 && ctrl_r.t0_run && tk0 && {th0_r, tl0_r} == 16'h0000 && !we_i
            |=> {th0_r, tl0_r} == {8'h00, $past(tl1_r)};
    endproperty
    a_mode0_reload: assert property (p_mode0_reload) else $error("mode 0 reload wrong");

    property p_mode4_reload;
        mode_r == DDT_MODE4 && ctrl_r.t1_run_a && tk1 && {th1_r, tl1_r} == 16'h0000 && !we_i
            |=> {th1_r, tl1_r} == {$past(th0_r), $past(tl0_r)} && ctrl_r.t1_run_a;
    endproperty
    a_mode4_reload: assert property (p_mode4_reload) else $error("mode 4 reload wrong");

    property p_baud_modes;
        baud_tick_o |-> $past(mode_r) inside {DDT_MODE1, DDT_MODE2, DDT_MODE3};
    endproperty
    a_baud_modes: assert property (p_baud_modes) else $error("baud tick in wrong mode");

    property p_mode_read;
        re_i && addr_i == `DDT_OFS_MODE ##1 1'b1
            |-> rdata_o == {4'h0, $past(xtal_en_r), $past(mode_r)};
    endproperty
    a_mode_read: assert property (p_mode_read) else $error("mode readback wrong");

    property p_rdata_idle;
        !re_i |=> rdata_o == 8'h00;
    endproperty
    a_rdata_idle: assert property (p_rdata_idle) else $error("read data outside slot");

endmodule

// ===== testbench/ddt_testbench.sv
// Self-checking bench for the dual down-timer: register access, modes and underflow.
// Assumes the design and package are compiled first and ddt_defs.svh is on the path.
`timescale 1ns/1ps
`include "ddt_defs.svh"

module testbench;
    import ddt_pkg::*;

    logic clk_i = 1'b0;
    logic reset_i = 1'b1;
    logic [`DDT_ADDR_W-1:0] addr_i = 3'h0;
    logic [`DDT_DATA_W-1:0] wdata_i = 8'h00;
    logic we_i = 1'b0;
    logic re_i = 1'b0;
    logic [`DDT_DATA_W-1:0] rdata_o;
    logic wake_io_pin_i = 1'b0;
    logic lp_osc_i = 1'b0;
    logic baud_tick_o;
    logic [7:0] rd_val;
    int failures = 0;
    int compares = 0;
    int ticks = 0;

    // Other oscillators tied low: counting runs off the wake pin and the slow oscillator
    ddt_timer ddt_timer_inst (
        .clk_i(clk_i),
        .reset_i(reset_i),
        .addr_i(addr_i),
        .wdata_i(wdata_i),
        .we_i(we_i),
        .re_i(re_i),
        .rdata_o(rdata_o),
        .rc12_osc_i(1'b0),
        .lp_osc_i(lp_osc_i),
        .rc90_osc_i(1'b0),
        .xtal_osc_i(1'b0),
        .wake_io_pin_i(wake_io_pin_i),
        .baud_tick_o(baud_tick_o)
    );

    always #5 clk_i = ~clk_i;

    always @(posedge clk_i) begin
        if (baud_tick_o === 1'b1) begin
            ticks++;
        end
    end

    // ****************************************
    // Helpers
    // ****************************************
    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        compares++;
        if (seen !== exp) begin
            failures++;
            $display("unexpected at %0t: saw %h, wanted %h", $time, seen, exp);
        end
    endtask

    task automatic wr(input logic [2:0] a, input logic [7:0] d);
        @(posedge clk_i);
        we_i <= 1'b1;
        addr_i <= a;
        wdata_i <= d;
        @(posedge clk_i);
        we_i <= 1'b0;
    endtask

    // Data stands only in the cycle after the strobe, so sample just after that edge
    task automatic rd(input logic [2:0] a);
        @(posedge clk_i);
        re_i <= 1'b1;
        addr_i <= a;
        @(posedge clk_i);
        re_i <= 1'b0;
        #1;
        rd_val = rdata_o;
    endtask

    // Levels held well past the three-stage synchroniser
    task automatic pulse();
        @(posedge clk_i);
        wake_io_pin_i <= 1'b1;
        repeat (6) @(posedge clk_i);
        wake_io_pin_i <= 1'b0;
        repeat (8) @(posedge clk_i);
    endtask

    // Each level change of the slow oscillator is one tick of the 4.4 kHz source
    task automatic lp_toggle();
        @(posedge clk_i);
        lp_osc_i <= ~lp_osc_i;
        repeat (8) @(posedge clk_i);
    endtask

    task automatic final_report();
        $display("compares=%0d failures=%0d", compares, failures);
        if (failures == 0 && compares > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask

    // ****************************************
    // Register rows: address, written, read back
    // ****************************************
    localparam int NROWS = 7;
    logic [2:0] row_a [NROWS] = '{3'h1, 3'h2, 3'h3, 3'h4, 3'h5, 3'h7, 3'h0};
    // Mode seven is never selected by this software
    logic [7:0] row_w [NROWS] = '{8'hfe, 8'ha5, 8'h5a, 8'h3c, 8'hc3, 8'hff, 8'hff};
    logic [7:0] row_e [NROWS] = '{8'h0e, 8'ha5, 8'h5a, 8'h3c, 8'hc3, 8'h7f, 8'h0f};

    initial begin
        #200000;
        failures++;
        final_report();
    end

    initial begin
        repeat (12) @(posedge clk_i);
        reset_i <= 1'b0;
        for (int i = 0; i < 8; i++) begin
            rd(i[2:0]);
            check(rd_val, 8'h00);
        end
        @(posedge clk_i);
        #1;
        check(rdata_o, 8'h00);
        // Module stays disabled, so run bits set here cannot count
        for (int i = 0; i < NROWS; i++) begin
            wr(row_a[i], row_w[i]);
            rd(row_a[i]);
            check(rd_val, row_e[i]);
        end
        for (int i = 0; i < 8; i++) begin
            wr(i[2:0], 8'h00);
        end
        // ****************************************
        // Disabled module, then mode 6 single run on the pin
        // ****************************************
        wr(3'h1, 8'h06);
        wr(3'h7, 8'h70);
        wr(3'h4, 8'h02);
        wr(3'h0, 8'h04);
        pulse();
        rd(3'h4);
        check(rd_val, 8'h02);
        wr(3'h6, 8'h01);
        pulse();
        rd(3'h4);
        check(rd_val, 8'h01);
        pulse();
        rd(3'h4);
        check(rd_val, 8'h00);
        pulse();
        rd(3'h0);
        check(rd_val, 8'h08);
        rd(3'h4);
        check(rd_val, 8'h00);
        // ****************************************
        // Mode 2 eight-bit reload with baud tick
        // ****************************************
        wr(3'h1, 8'h02);
        wr(3'h5, 8'h05);
        wr(3'h4, 8'h01);
        wr(3'h0, 8'h04);
        ticks = 0;
        pulse();
        rd(3'h4);
        check(rd_val, 8'h00);
        pulse();
        rd(3'h4);
        check(rd_val, 8'h05);
        rd(3'h0);
        check(rd_val, 8'h0c);
        check(8'(ticks), 8'h01);
        wr(3'h0, 8'h04);
        rd(3'h0);
        check(rd_val, 8'h04);
        // ****************************************
        // Mode 4 sixteen-bit reload from the timer zero pair
        // ****************************************
        wr(3'h0, 8'h00);
        wr(3'h1, 8'h04);
        wr(3'h2, 8'h34);
        wr(3'h3, 8'h12);
        wr(3'h4, 8'h00);
        wr(3'h5, 8'h00);
        wr(3'h0, 8'h04);
        pulse();
        rd(3'h4);
        check(rd_val, 8'h34);
        rd(3'h5);
        check(rd_val, 8'h12);
        rd(3'h0);
        check(rd_val, 8'h0c);
        // ****************************************
        // Mode 1: timer zero chained on timer one underflow
        // ****************************************
        wr(3'h0, 8'h00);
        wr(3'h1, 8'h01);
        wr(3'h7, 8'h77);
        wr(3'h4, 8'h00);
        wr(3'h5, 8'h00);
        wr(3'h2, 8'h00);
        wr(3'h3, 8'h01);
        wr(3'h0, 8'h05);
        ticks = 0;
        pulse();
        rd(3'h2);
        check(rd_val, 8'hff);
        rd(3'h3);
        check(rd_val, 8'h00);
        rd(3'h0);
        check(rd_val, 8'h0d);
        check(8'(ticks), 8'h01);
        // ****************************************
        // Timer zero on the slow oscillator: modes 0, 2, 3, 6
        // ****************************************
        wr(3'h0, 8'h00);
        wr(3'h1, 8'h00);
        wr(3'h7, 8'h75);
        wr(3'h4, 8'h03);
        wr(3'h2, 8'h00);
        wr(3'h3, 8'h00);
        wr(3'h0, 8'h01);
        lp_toggle();
        rd(3'h2);
        check(rd_val, 8'h03);
        rd(3'h0);
        check(rd_val, 8'h03);
        wr(3'h0, 8'h00);
        wr(3'h1, 8'h02);
        wr(3'h3, 8'h07);
        wr(3'h2, 8'h00);
        wr(3'h0, 8'h01);
        lp_toggle();
        rd(3'h2);
        check(rd_val, 8'h07);
        rd(3'h0);
        check(rd_val, 8'h03);
        wr(3'h0, 8'h00);
        wr(3'h1, 8'h03);
        wr(3'h2, 8'h01);
        wr(3'h3, 8'h00);
        wr(3'h0, 8'h05);
        lp_toggle();
        rd(3'h0);
        check(rd_val, 8'h09);
        lp_toggle();
        rd(3'h0);
        check(rd_val, 8'h0a);
        rd(3'h2);
        check(rd_val, 8'h00);
        wr(3'h0, 8'h00);
        wr(3'h1, 8'h06);
        wr(3'h2, 8'h00);
        wr(3'h3, 8'h00);
        wr(3'h0, 8'h01);
        lp_toggle();
        rd(3'h0);
        check(rd_val, 8'h02);
        lp_toggle();
        rd(3'h2);
        check(rd_val, 8'h00);
        rd(3'h0);
        check(rd_val, 8'h02);
        // ****************************************
        // Mode 5: timer one sixteen-bit single run on the pin
        // ****************************************
        wr(3'h0, 8'h00);
        wr(3'h1, 8'h05);
        wr(3'h4, 8'h00);
        wr(3'h5, 8'h00);
        wr(3'h0, 8'h04);
        pulse();
        rd(3'h0);
        check(rd_val, 8'h08);
        wr(3'h6, 8'h00);
        final_report();
    end

endmodule
